// ===== pkg/adc_fmt_pkg.sv
// Purpose: Shared constants for the converter output formatter and configuration port.
// Assumes: 200 MHz reference clock; serial clock and strap pins are asynchronous.
// Notes: Register addresses, field positions, reset values and cycle counts.
package adc_fmt_pkg;
    localparam int DATA_W = 12;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [6:0] ADDR_POWER = 7'h01;
    localparam logic [6:0] ADDR_TIMING = 7'h02;
    localparam logic [6:0] ADDR_OUTMODE = 7'h03;
    localparam logic [6:0] ADDR_FORMAT = 7'h04;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam int RST_BIT = 7;
    localparam int PWR_SLEEP_BIT = 3;
    localparam int PWR_NAP_BIT = 2;
    localparam int PWR_CHB_BIT = 1;
    localparam int TIM_DCS_BIT = 0;
    localparam int OUT_HIZ_BIT = 0;
    localparam int OUT_CUR_LSB = 2;
    localparam int FMT_PAT_LSB = 5;
    localparam int FMT_ALTPOL_BIT = 4;
    localparam int FMT_PATEN_BIT = 2;
    localparam int FMT_SCRAM_BIT = 1;
    localparam int FMT_SIGNED_BIT = 0;
    localparam logic [2:0] PAT_ZEROS = 3'h0;
    localparam logic [2:0] PAT_ONES = 3'h1;
    localparam logic [2:0] PAT_TOGGLE = 3'h2;
    localparam logic [2:0] PAT_CHECKER = 3'h4;
    localparam logic [2:0] CUR_LOW_STRAP = 3'h7;
    localparam logic [2:0] CUR_DEFAULT = 3'h0;
    localparam logic [4:0] SER_WORD_BITS = 5'h10;
    localparam int NAP_WAKE_CYCLES = 100;
    localparam logic [6:0] NAP_WAKE_CNT = 7'(NAP_WAKE_CYCLES);
    localparam logic [12:0] CHECKER_A = 13'h1555;
endpackage

// ===== src/adc_output_format_and_config_port.sv
// Purpose: Sample formatter, test patterns, power modes and serial configuration port.
// Assumes: Serial clock, chip select, data-in and straps are asynchronous to ref_clk.
// Notes: Outputs are single-rate words; the pad logic serialises them.
module adc_output_format_and_config_port
    import adc_fmt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [adc_fmt_pkg::DATA_W-1:0] raw_a,
    input wire logic [adc_fmt_pkg::DATA_W-1:0] raw_b,
    input wire logic over_a,
    input wire logic under_a,
    input wire logic over_b,
    input wire logic under_b,
    input wire logic sample_valid,
    input wire logic programming_select,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe,
    output logic [adc_fmt_pkg::DATA_W-1:0] data_a,
    output logic [adc_fmt_pkg::DATA_W-1:0] data_b,
    output logic overflow_flag_a,
    output logic overflow_flag_b,
    output logic output_strobe_clock,
    output logic outputs_oe,
    output logic sleep_mode,
    output logic nap_mode,
    output logic second_channel_powerdown,
    output logic duty_stabilizer_enable,
    output logic [2:0] drive_current_sel,
    output logic data_valid
);
    import adc_fmt_pkg::*;

    // Two-flop synchronisers for all asynchronous pins.
    // A pin that moves near a clock edge settles here before any decode reads it.
    logic [3:0] sync1_ff, sync2_ff;
    always_ff @(posedge ref_clk)
    begin
        sync1_ff <= {programming_select, cs_n, sck, sdi};
        sync2_ff <= sync1_ff;
    end
    wire par_mode = sync2_ff[3];
    wire cs_s = sync2_ff[2];
    wire sck_s = sync2_ff[1];
    wire sdi_s = sync2_ff[0];

    // Delayed copies of the synchronised serial clock and chip select turn their transitions into one-cycle strobes.
    logic sck_d_ff, cs_d_ff;
    always_ff @(posedge ref_clk)
    begin
        sck_d_ff <= sck_s;
        cs_d_ff <= cs_s;
    end
    wire sck_rise = sck_s & ~sck_d_ff;
    wire sck_fall = ~sck_s & sck_d_ff;
    wire cs_fall = ~cs_s & cs_d_ff;

    // Serial shift state.
    logic [4:0] bit_cnt_ff;
    logic [15:0] shift_ff;
    logic [7:0] rd_shift_ff;
    logic sdo_low_ff;
    logic [7:0] power_ff, timing_ff, outmode_ff, format_ff;

    // Readback decode; the reset register and unmapped addresses read as zero.
    function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] p,
        input logic [7:0] t, input logic [7:0] o, input logic [7:0] f);
        unique case (a)
            ADDR_POWER: reg_read = p;
            ADDR_TIMING: reg_read = t;
            ADDR_OUTMODE: reg_read = o;
            ADDR_FORMAT: reg_read = f;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // Word decode. The counter limit drops serial clock rises past the sixteenth,
    // so a host that over-clocks a frame cannot disturb the word already taken.
    wire ser_active = ~cs_s & ~par_mode;
    wire take_bit = ser_active & sck_rise & (bit_cnt_ff < SER_WORD_BITS);
    wire [15:0] nxt_shift = {shift_ff[14:0], sdi_s};
    wire [4:0] nxt_cnt = bit_cnt_ff + 5'h01;
    wire word_done = take_bit & (nxt_cnt == SER_WORD_BITS);
    wire do_write = word_done & ~nxt_shift[15];
    wire [6:0] wr_addr = nxt_shift[14:8];
    wire [7:0] wr_data = nxt_shift[7:0];
    wire soft_reset = do_write & (wr_addr == ADDR_RESET) & wr_data[RST_BIT];
    wire rd_load = take_bit & (nxt_cnt == 5'h08) & shift_ff[6];
    wire [7:0] rd_val = reg_read(nxt_shift[6:0], power_ff, timing_ff, outmode_ff, format_ff);

    // Bit counter restarts on select fall and clears when select rises early.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || cs_s || cs_fall)
            bit_cnt_ff <= 5'h00;
        else if (take_bit)
            bit_cnt_ff <= nxt_cnt;
    end

    // The shift register takes one data-in bit per accepted serial clock rise.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            shift_ff <= 16'h0000;
        else if (take_bit)
            shift_ff <= nxt_shift;
    end

    // Readback: register loaded after address, shifted out on falling edges.
    // An idle shifter holds ones, so the open-drain line stays released.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || cs_s)
            rd_shift_ff <= 8'hff;
        else if (rd_load)
            rd_shift_ff <= rd_val;
        else if (sck_fall && bit_cnt_ff > 5'h08)
            rd_shift_ff <= {rd_shift_ff[6:0], 1'b1};
    end

    // Open drain: only ever pulls low.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            sdo_low_ff <= 1'b0;
        else
            sdo_low_ff <= ser_active && bit_cnt_ff >= 5'h08 && !rd_shift_ff[7];
    end
    assign sdo_oe = sdo_low_ff;
    assign sdo_o = 1'b0;

    // Mode registers: written by a complete word, cleared by software reset.
    // Reserved bits are masked so that readback always shows them as zero.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || soft_reset)
        begin
            power_ff <= REG_RESET_VAL;
            timing_ff <= REG_RESET_VAL;
            outmode_ff <= REG_RESET_VAL;
            format_ff <= REG_RESET_VAL;
        end
        else if (do_write)
        begin
            if (wr_addr == ADDR_POWER)
                power_ff <= wr_data & 8'h0e;
            if (wr_addr == ADDR_TIMING)
                timing_ff <= wr_data & 8'h0f;
            if (wr_addr == ADDR_OUTMODE)
                outmode_ff <= wr_data & 8'h1f;
            if (wr_addr == ADDR_FORMAT)
                format_ff <= wr_data & 8'hf7;
        end
    end

    // Effective modes: straps in parallel mode, registers in serial mode.
    // Features with no strap fall back to their reset state in parallel mode.
    wire m_sleep = par_mode ? sck_s : power_ff[PWR_SLEEP_BIT];
    wire m_nap = ~par_mode & power_ff[PWR_NAP_BIT];
    wire m_chb = ~par_mode & power_ff[PWR_CHB_BIT];
    wire m_dcs = par_mode ? cs_s : timing_ff[TIM_DCS_BIT];
    wire [2:0] m_cur = par_mode ? (sdi_s ? CUR_LOW_STRAP : CUR_DEFAULT)
                                : outmode_ff[OUT_CUR_LSB +: 3];
    wire m_hiz = ~par_mode & outmode_ff[OUT_HIZ_BIT];
    wire m_signed = ~par_mode & format_ff[FMT_SIGNED_BIT];
    wire m_scram = ~par_mode & format_ff[FMT_SCRAM_BIT];
    wire m_altpol = ~par_mode & format_ff[FMT_ALTPOL_BIT];
    wire m_paten = ~par_mode & format_ff[FMT_PATEN_BIT];
    wire [2:0] m_pat = format_ff[FMT_PAT_LSB +: 3];

    // Formatting of one channel: saturate, sign, scramble, then polarity.
    // Clipping before the sign flip makes both formats saturate at matching codes.
    function automatic logic [12:0] fmt(input logic [11:0] raw, input logic ov,
        input logic un, input logic sgn, input logic scr, input logic alt);
        logic [11:0] d;
        d = ov ? 12'hfff : (un ? 12'h000 : raw);
        if (sgn)
            d[11] = ~d[11];
        if (scr)
            d[11:1] = d[11:1] ^ {11{d[0]}};
        if (alt)
            d = d ^ 12'haaa;
        fmt = {ov | un, d};
    endfunction

    // Test pattern words; the phase flips on every sample so alternating patterns
    // follow the strobe. Unused pattern codes fall through to all zeros.
    logic pat_phase_ff;
    wire [12:0] pat_word = (m_pat == PAT_ONES) ? 13'h1fff :
                           (m_pat == PAT_TOGGLE) ? {13{pat_phase_ff}} :
                           (m_pat == PAT_CHECKER) ? (pat_phase_ff ? ~CHECKER_A : CHECKER_A) :
                           13'h0000;
    // A pattern bypasses all formatting, so the receiver sees it untouched.
    wire [12:0] word_a = m_paten ? pat_word
                       : fmt(raw_a, over_a, under_a, m_signed, m_scram, m_altpol);
    wire [12:0] word_b = m_paten ? pat_word
                       : fmt(raw_b, over_b, under_b, m_signed, m_scram, m_altpol);

    // Nap wake counter holds data invalid for the recovery interval.
    // The count restarts while either power-down is held, so it times from the exit.
    logic [6:0] wake_cnt_ff;
    logic nap_d_ff;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wake_cnt_ff <= 7'h00;
            nap_d_ff <= 1'b0;
        end
        else
        begin
            nap_d_ff <= m_nap | m_sleep;
            if (m_nap || m_sleep)
                wake_cnt_ff <= NAP_WAKE_CNT;
            else if (wake_cnt_ff != 7'h00)
                wake_cnt_ff <= wake_cnt_ff - 7'h01;
        end
    end
    wire powered = ~m_sleep & ~m_nap & ~nap_d_ff & (wake_cnt_ff == 7'h00);

    // Output stage registers.
    // A powered-down channel B presents zeros so its pins stay quiet.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            data_a <= 12'h000;
            data_b <= 12'h000;
            overflow_flag_a <= 1'b0;
            overflow_flag_b <= 1'b0;
            output_strobe_clock <= 1'b0;
            pat_phase_ff <= 1'b0;
            data_valid <= 1'b0;
            outputs_oe <= 1'b0;
        end
        else
        begin
            outputs_oe <= ~m_hiz;
            data_valid <= sample_valid & powered;
            if (sample_valid)
            begin
                data_a <= word_a[11:0];
                overflow_flag_a <= word_a[12];
                data_b <= m_chb ? 12'h000 : word_b[11:0];
                overflow_flag_b <= m_chb ? 1'b0 : word_b[12];
                output_strobe_clock <= ~output_strobe_clock;
                pat_phase_ff <= ~pat_phase_ff;
            end
        end
    end

    // Power and analog control levels.
    // Registering them keeps decode glitches away from the analog controls.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sleep_mode <= 1'b0;
            nap_mode <= 1'b0;
            second_channel_powerdown <= 1'b0;
            duty_stabilizer_enable <= 1'b0;
            drive_current_sel <= CUR_DEFAULT;
        end
        else
        begin
            sleep_mode <= m_sleep;
            nap_mode <= m_nap;
            second_channel_powerdown <= m_chb;
            duty_stabilizer_enable <= m_dcs;
            drive_current_sel <= m_cur;
        end
    end
endmodule

// ===== verif/adc_fmt_asserts.sv
// Purpose: Port-level checks of the formatter and configuration port.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Attached to the top module by the bind at the foot.
module adc_fmt_asserts
    import adc_fmt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [adc_fmt_pkg::DATA_W-1:0] data_a,
    input wire logic overflow_flag_a,
    input wire logic sample_valid,
    input wire logic programming_select,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic output_strobe_clock,
    input wire logic sleep_mode,
    input wire logic nap_mode,
    input wire logic duty_stabilizer_enable,
    input wire logic [2:0] drive_current_sel,
    input wire logic data_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Cycles since the last powered-down cycle; saturates so a long run never wraps.
    logic [6:0] wake_ff;
    always_ff @(posedge ref_clk)
    begin
        wake_ff <= !rst_n ? 7'h7f : (nap_mode || sleep_mode) ? 7'h00 :
            wake_ff + 7'(wake_ff != 7'h7f);
    end
    // Each strap held steady in parallel mode long enough to pass the synchronisers.
    sequence par_sck_hi;
        (programming_select && sck) [*8];
    endsequence
    sequence par_sdi_hi;
        (programming_select && sdi) [*8];
    endsequence
    sequence par_cs_hi;
        (programming_select && cs_n) [*8];
    endsequence
    a_sdo_low_only: assert property (sdo_oe |-> !sdo_o)
        else $error("data-out driven high");
    a_sdo_release: assert property ((!programming_select && cs_n) [*6] |-> !sdo_oe)
        else $error("data-out held after deselect");
    a_valid_cause: assert property (data_valid |-> $past(sample_valid))
        else $error("valid without a sample");
    a_nap_wake: assert property (data_valid |-> wake_ff >= 7'h63)
        else $error("valid too soon after power-up");
    a_strobe_step: assert property (sample_valid && !sleep_mode && !nap_mode
        |=> $changed(output_strobe_clock)) else $error("strobe did not toggle");
    a_data_hold: assert property (!$past(sample_valid) && $stable(sleep_mode)
        |-> $stable(data_a) && $stable(overflow_flag_a)) else $error("data moved");
    a_strap_sleep: assert property (par_sck_hi |-> sleep_mode)
        else $error("sleep strap ignored");
    a_strap_current: assert property (par_sdi_hi |-> drive_current_sel == CUR_LOW_STRAP)
        else $error("current strap ignored");
    a_strap_dcs: assert property (par_cs_hi |-> duty_stabilizer_enable)
        else $error("stabilizer strap ignored");
endmodule
bind adc_output_format_and_config_port adc_fmt_asserts chk_u (.*);

// ===== verif/cfg_host_model.sv
// Purpose: Configuration controller that drives the serial port or the straps.
// Assumes: Serial clock idles low between frames; the data-out line has a pull-up.
// Notes: Frames use a 48 ns serial clock period.
module cfg_host_model
(
    input wire logic sdo_o,
    input wire logic sdo_oe,
    output logic cs_n,
    output logic sck,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 100ps;
    // The pull-up gives the open-drain line its high level.
    wire sdo_w = sdo_oe ? sdo_o : 1'b1;
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // Sends n bits MSB first; the bits after the eighth come back from data-out in rd.
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            sdi = w[15 - i];
            #24;
            if (i > 7)
                rd[15 - i] = sdo_w;
            sck = 1'b1;
            #24;
            sck = 1'b0;
        end
        #24;
        cs_n = 1'b1;
        sdi = ~sdi;
        #48;
    endtask
    // Sets chip select, serial clock and data-in as static straps.
    task automatic strap(input logic [2:0] v);
        {cs_n, sck, sdi} = v;
    endtask
endmodule

// ===== verif/adc_output_format_and_config_port_tb.sv
// Purpose: Self-checking bench for the formatter and configuration port.
// Assumes: Serial pins and straps come from the controller model.
// Notes: The driver queues expected samples; a monitor pops one per valid output.
`define CHK(nm, got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("BAD %s exp %h got %h", nm, exp, got); \
        end \
    end
module adc_output_format_and_config_port_tb import adc_fmt_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, sample_valid = 1'b0, programming_select = 1'b0;
    logic over_a = 1'b0, under_a = 1'b0, over_b = 1'b0, under_b = 1'b0, pd_b = 1'b0;
    logic [DATA_W-1:0] raw_a = 12'h000, raw_b = 12'h000, data_a, data_b;
    logic overflow_flag_a, overflow_flag_b, output_strobe_clock, outputs_oe, sleep_mode;
    logic nap_mode, second_channel_powerdown, duty_stabilizer_enable, data_valid;
    logic cs_n, sck, sdi, sdo_o, sdo_oe;
    logic [2:0] drive_current_sel;
    logic [2:0] pats [4] = '{PAT_ZEROS, PAT_ONES, PAT_TOGGLE, PAT_CHECKER};
    logic [7:0] fmt_cur = 8'h00, rd;
    logic [33:0] e;
    logic [7:0] last_f = 8'h00;
    logic [12:0] last_w = 13'h0000;
    logic [33:0] exp_q [$];
    int mismatches = 0, checks_done = 0, cycles = 0;
    // Clock keeps running through nap so the short wake-up applies
    always #2.5 ref_clk = ~ref_clk;
    adc_output_format_and_config_port dut_u (.*);
    cfg_host_model host_u (.*);
    // Expected word of one channel before scrambling and polarity.
    function automatic logic [12:0] want(logic [7:0] f, logic [11:0] r, logic ov, logic un);
        if (f[FMT_PATEN_BIT])
            return f[7:5] == PAT_ONES ? 13'h1fff : f[7:5] == PAT_CHECKER ? CHECKER_A : 13'h0000;
        return {ov | un, (ov ? 12'hfff : un ? 12'h000 : r) ^ {f[FMT_SIGNED_BIT], 11'h000}};
    endfunction
    // Receiver: undo polarity, then descramble; a toggling pattern may be in either phase.
    function automatic logic [12:0] rx(logic [7:0] f, logic [12:0] w, logic [12:0] x);
        if (f[FMT_PATEN_BIT])
            return ((f[6] | f[7]) && w == (x ^ 13'h1fff)) ? x : w;
        w[11:0] = w[11:0] ^ {6{f[FMT_ALTPOL_BIT], 1'b0}};
        w[11:1] = w[11:1] ^ {11{f[FMT_SCRAM_BIT] & w[0]}};
        return w;
    endfunction
    // Back-to-back samples with random codes and at most one range flag.
    task automatic smp(input int n, input logic keep);
        repeat (n)
        begin
            @(posedge ref_clk);
            #1;
            {raw_a, raw_b} = 24'($urandom);
            {over_a, under_a, over_b, under_b} = 4'(4'h1 << ($urandom % 8));
            sample_valid = 1'b1;
            if (keep)
                exp_q.push_back({fmt_cur, pd_b ? 13'h0000 : want(fmt_cur, raw_b, over_b, under_b),
                    want(fmt_cur, raw_a, over_a, under_a)});
        end
        @(posedge ref_clk);
        #1;
        sample_valid = 1'b0;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer({1'b0, a, d}, 16, rd);
        fmt_cur = a == ADDR_FORMAT ? d : a == ADDR_RESET ? 8'h00 : fmt_cur;
    endtask
    // Read with random data on data-in, which must be ignored.
    task automatic rdc(input logic [6:0] a, input logic [7:0] x, input string nm);
        host_u.xfer({1'b1, a, 8'($urandom)}, 16, rd);
        `CHK(nm, rd, x)
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Monitor: oldest note against each presented sample, decoded as a receiver would.
    always @(posedge ref_clk)
    begin
        if (data_valid === 1'b1)
        begin
            `CHK("note", exp_q.size() > 0, 1'b1)
            e = exp_q.size() > 0 ? exp_q.pop_front() : 34'h0;
            `CHK("chan_a", rx(e[33:26], {overflow_flag_a, data_a}, e[12:0]), e[12:0])
            `CHK("chan_b", rx(e[33:26], {overflow_flag_b, data_b}, e[25:13]), e[25:13])
            // Alternating patterns must flip on each consecutive sample of one setting.
            if (e[33:26] == last_f && e[28] && (e[32] || e[33]))
                `CHK("phase", {overflow_flag_a, data_a}, ~last_w)
            last_f = e[33:26];
            last_w = {overflow_flag_a, data_a};
        end
    end
    // Cuts a hang short.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            mismatches++;
            complete_run();
        end
    end
    initial
    begin
        void'($urandom(32'h10cf1607));
        repeat (12) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        rdc(ADDR_POWER, 8'h00, "power");
        rdc(ADDR_OUTMODE, 8'h00, "outmode");
        rdc(7'h55, 8'h00, "unmapped");
        `CHK("oe", outputs_oe, 1'b1)
        smp(3, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 16; i++)
        begin
            wr(ADDR_FORMAT, {pats[i % 4], i[3], 1'b0, i[2], 2'($urandom)});
            rdc(ADDR_FORMAT, fmt_cur, "format");
            smp(3, 1'b1);
        end
        host_u.xfer({1'b0, ADDR_FORMAT, 8'hff}, 10, rd);
        rdc(ADDR_FORMAT, fmt_cur, "short");
        $display("test format done");
        wr(ADDR_OUTMODE, 8'h1d);
        `CHK("hiz", outputs_oe, 1'b0)
        `CHK("cur", drive_current_sel, 3'h7)
        wr(ADDR_TIMING, 8'h01);
        `CHK("dcs", duty_stabilizer_enable, 1'b1)
        wr(ADDR_RESET, 8'h80);
        rdc(ADDR_OUTMODE, 8'h00, "softrst");
        rdc(ADDR_RESET, 8'h00, "rstbit");
        `CHK("oe", outputs_oe, 1'b1)
        $display("test outmode done");
        wr(ADDR_POWER, 8'h03);
        pd_b = 1'b1;
        rdc(ADDR_POWER, 8'h02, "power");
        `CHK("pdb", second_channel_powerdown, 1'b1)
        smp(3, 1'b1);
        wr(ADDR_POWER, 8'h04);
        pd_b = 1'b0;
        `CHK("nap", nap_mode, 1'b1)
        wr(ADDR_POWER, 8'h00);
        smp(2, 1'b0);
        repeat (110) @(posedge ref_clk);
        smp(2, 1'b1);
        wr(ADDR_POWER, 8'h08);
        `CHK("sleep", sleep_mode, 1'b1)
        smp(2, 1'b0);
        wr(ADDR_POWER, 8'h00);
        repeat (22500) @(posedge ref_clk);
        smp(2, 1'b1);
        $display("test power done");
        programming_select = 1'b1;
        for (int v = 0; v < 8; v++)
        begin
            host_u.strap(3'(v));
            repeat (10) @(posedge ref_clk);
            #1;
            `CHK("s_dcs", duty_stabilizer_enable, v[2])
            `CHK("s_sleep", sleep_mode, v[1])
            `CHK("s_cur", drive_current_sel, v[0] ? CUR_LOW_STRAP : CUR_DEFAULT)
        end
        `CHK("left", exp_q.size(), 0)
        $display("test straps done");
        complete_run();
    end
endmodule
